// *** verilog/sreg_regs.vh ***
// Register map, field positions and reset values of the status event register group
`ifndef SREG_REGS_VH
`define SREG_REGS_VH
`define SREG_ADDR_OPER_MASK 2'h0
`define SREG_ADDR_QUES_LATCH 2'h1
`define SREG_ADDR_QUES_MASK 2'h2
`define SREG_OPER_MASK_RST 16'h0000
`define SREG_QUES_MASK_RST 16'h0000
`define SREG_QUES_USED 16'h7ffe
`define SREG_BIT_UNUSED_HI 15
`define SREG_BIT_PWR_SWITCH_OFF 14
`define SREG_BIT_PAR_WAIT 13
`define SREG_BIT_PAR_ERROR 12
`define SREG_BIT_GEN_ERROR 11
`define SREG_BIT_PAR_ACK 10
`define SREG_BIT_UNDER_VOLT 9
`define SREG_BIT_ENABLE_FAULT 8
`define SREG_BIT_INTERLOCK 7
`define SREG_BIT_OUT_OFF 6
`define SREG_BIT_SHUT_OFF 5
`define SREG_BIT_OVER_VOLT 4
`define SREG_BIT_FOLDBACK 3
`define SREG_BIT_OVER_TEMP 2
`define SREG_BIT_AC_FAULT 1
`define SREG_BIT_UNUSED_LO 0
`endif

// *** verilog/sreg_latch_bit.v ***
// One sticky event bit with clear-on-read; a new event wins over the clear
`timescale 1ns/1ps
module sreg_latch_bit
(
  input wire clk_i,
  input wire resetn_i,
  input wire ce_i,
  input wire set_i,
  input wire clr_i,
  output reg q_o
);
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      q_o <= 1'b0;
    else if (ce_i)
    begin
      if (set_i)
        q_o <= 1'b1;
      else if (clr_i)
        q_o <= 1'b0;
    end
  end
endmodule

// *** verilog/sreg_status_group.v ***
// Operational enable mask and questionable event latch register group
//
// Overview of operation
// - 16-bit operational mask; set bits pass operational condition bits into events.
// - Mask stores any written value 0..65535 and reads it back unchanged.
// - Questionable event register is read-only; writes to it do nothing.
// - Event bit sets only when condition and questionable mask bits both set.
// - Bit 13 reports master waiting for slave units in parallel system.
// - Bit 12 sets on advanced parallel system error.
// - Bit 6 sets while DC output is switched off.
// - Bit 5 sets when external shut-off input is high.
// - Bit 4 sets on over-voltage protection fault.
// - Bit 9 sets on under-voltage protection fault.
// - Bit 3 sets on foldback fault.
// - Bit 10 acknowledges a new parallel system configuration.
`timescale 1ns/1ps
`include "sreg_regs.vh"
module sreg_status_group
#(
  parameter WIDTH = 16
)
(
  input wire CLK_I,
  input wire RESETN_I,
  input wire CE_I,
  input wire [1:0] REG_ADDR_I,
  input wire REG_WR_I,
  input wire REG_RD_I,
  input wire [WIDTH-1:0] REG_WDATA_I,
  output reg [WIDTH-1:0] REG_RDATA_O,
  output reg REG_RVALID_O,
  input wire [WIDTH-1:0] OPER_COND_I,
  input wire POWER_SWITCH_OFF_FLAG_I,
  input wire PARALLEL_WAIT_SLAVES_FLAG_I,
  input wire PARALLEL_ERROR_FLAG_I,
  input wire GENERAL_ERROR_FLAG_I,
  input wire PARALLEL_ACK_FLAG_I,
  input wire UNDER_VOLTAGE_FAULT_FLAG_I,
  input wire ENABLE_FAULT_FLAG_I,
  input wire INTERLOCK_FAULT_FLAG_I,
  input wire OUTPUT_OFF_FLAG_I,
  input wire SHUT_OFF_FLAG_I,
  input wire OVER_VOLTAGE_FAULT_FLAG_I,
  input wire FOLDBACK_FAULT_FLAG_I,
  input wire OVER_TEMP_FAULT_FLAG_I,
  input wire AC_FAULT_FLAG_I,
  output reg [WIDTH-1:0] OPER_EVENT_O,
  output reg [WIDTH-1:0] OPER_MASK_O,
  output reg [WIDTH-1:0] QUES_EVENT_O
);
  // ==========================================================
  // Internal state and next values
  reg [WIDTH-1:0] oper_mask_r;
  reg [WIDTH-1:0] oper_mask_nxt;
  reg [WIDTH-1:0] ques_mask_r;
  reg [WIDTH-1:0] ques_mask_nxt;
  reg [WIDTH-1:0] rdata_nxt;
  wire [WIDTH-1:0] oper_event_nxt;
  wire [WIDTH-1:0] ques_latch;
  wire [WIDTH-1:0] ques_cond;
  wire [WIDTH-1:0] ques_set;
  wire wr_oper_mask;
  wire wr_ques_mask;
  wire ques_clr;

  // ==========================================================
  // Address decode
  // The event latch address has no write decode, so host writes there are lost
  assign wr_oper_mask = REG_WR_I && (REG_ADDR_I == `SREG_ADDR_OPER_MASK);
  assign wr_ques_mask = REG_WR_I && (REG_ADDR_I == `SREG_ADDR_QUES_MASK);
  assign ques_clr = REG_RD_I && (REG_ADDR_I == `SREG_ADDR_QUES_LATCH);

  // ==========================================================
  // Mask registers
  always @*
  begin
    oper_mask_nxt = oper_mask_r;
    if (wr_oper_mask)
      oper_mask_nxt = REG_WDATA_I;
  end

  always @*
  begin
    ques_mask_nxt = ques_mask_r;
    if (wr_ques_mask)
      ques_mask_nxt = REG_WDATA_I;
  end

  always @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      oper_mask_r <= `SREG_OPER_MASK_RST;
    end
    else if (CE_I)
    begin
      oper_mask_r <= oper_mask_nxt;
    end
  end

  always @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      ques_mask_r <= `SREG_QUES_MASK_RST;
    end
    else if (CE_I)
    begin
      ques_mask_r <= ques_mask_nxt;
    end
  end

  // ==========================================================
  // Questionable condition vector
  assign ques_cond[`SREG_BIT_UNUSED_HI] = 1'b0;
  assign ques_cond[`SREG_BIT_PWR_SWITCH_OFF] = POWER_SWITCH_OFF_FLAG_I;
  assign ques_cond[`SREG_BIT_PAR_WAIT] = PARALLEL_WAIT_SLAVES_FLAG_I;
  assign ques_cond[`SREG_BIT_PAR_ERROR] = PARALLEL_ERROR_FLAG_I;
  assign ques_cond[`SREG_BIT_GEN_ERROR] = GENERAL_ERROR_FLAG_I;
  assign ques_cond[`SREG_BIT_PAR_ACK] = PARALLEL_ACK_FLAG_I;
  assign ques_cond[`SREG_BIT_UNDER_VOLT] = UNDER_VOLTAGE_FAULT_FLAG_I;
  assign ques_cond[`SREG_BIT_ENABLE_FAULT] = ENABLE_FAULT_FLAG_I;
  assign ques_cond[`SREG_BIT_INTERLOCK] = INTERLOCK_FAULT_FLAG_I;
  assign ques_cond[`SREG_BIT_OUT_OFF] = OUTPUT_OFF_FLAG_I;
  assign ques_cond[`SREG_BIT_SHUT_OFF] = SHUT_OFF_FLAG_I;
  assign ques_cond[`SREG_BIT_OVER_VOLT] = OVER_VOLTAGE_FAULT_FLAG_I;
  assign ques_cond[`SREG_BIT_FOLDBACK] = FOLDBACK_FAULT_FLAG_I;
  assign ques_cond[`SREG_BIT_OVER_TEMP] = OVER_TEMP_FAULT_FLAG_I;
  assign ques_cond[`SREG_BIT_AC_FAULT] = AC_FAULT_FLAG_I;
  assign ques_cond[`SREG_BIT_UNUSED_LO] = 1'b0;

  // A mask bit alone never sets an event; the condition must be high as well
  assign ques_set = ques_cond & ques_mask_r & `SREG_QUES_USED;
  assign oper_event_nxt = OPER_COND_I & oper_mask_r;

  // ==========================================================
  // Sticky event latch, one cell per bit
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_bit
      sreg_latch_bit u_bit
      (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .ce_i(CE_I),
        .set_i(ques_set[g]),
        .clr_i(ques_clr),
        .q_o(ques_latch[g])
      );
    end
  endgenerate

  // ==========================================================
  // Read data select
  // The latch is sampled before the edge that clears it, so no event is lost
  always @*
  begin
    case (REG_ADDR_I)
      `SREG_ADDR_OPER_MASK: rdata_nxt = oper_mask_r;
      `SREG_ADDR_QUES_LATCH: rdata_nxt = ques_latch;
      `SREG_ADDR_QUES_MASK: rdata_nxt = ques_mask_r;
      default: rdata_nxt = {WIDTH{1'b0}};
    endcase
  end

  // ==========================================================
  // Registered outputs
  always @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      REG_RVALID_O <= 1'b0;
    end
    else if (CE_I)
    begin
      REG_RVALID_O <= REG_RD_I;
    end
  end

  always @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      REG_RDATA_O <= {WIDTH{1'b0}};
    end
    else if (CE_I && REG_RD_I)
    begin
      REG_RDATA_O <= rdata_nxt;
    end
  end

  always @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      OPER_EVENT_O <= {WIDTH{1'b0}};
    end
    else if (CE_I)
    begin
      OPER_EVENT_O <= oper_event_nxt;
    end
  end

  always @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      OPER_MASK_O <= {WIDTH{1'b0}};
    end
    else if (CE_I)
    begin
      OPER_MASK_O <= oper_mask_r;
    end
  end

  always @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      QUES_EVENT_O <= {WIDTH{1'b0}};
    end
    else if (CE_I)
    begin
      QUES_EVENT_O <= ques_latch;
    end
  end
endmodule

// *** verification/sreg_status_group_asserts.sv ***
// Checker for the status event register group
`timescale 1ns/1ps
module sreg_asserts
(
  input wire CLK_I,
  input wire RESETN_I,
  input wire CE_I,
  input wire [1:0] REG_ADDR_I,
  input wire REG_WR_I,
  input wire REG_RD_I,
  input wire [15:0] REG_WDATA_I,
  input wire [15:0] REG_RDATA_O,
  input wire REG_RVALID_O,
  input wire [15:0] OPER_COND_I,
  input wire [15:0] OPER_EVENT_O,
  input wire [15:0] OPER_MASK_O,
  input wire [15:0] QUES_EVENT_O
);
  // ====
  // Checks, all one domain
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  sequence s_wr;
    CE_I && REG_WR_I && REG_ADDR_I == 2'h0 ##1 CE_I;
  endsequence
  chk_rd_valid: assert property (CE_I && REG_RD_I |=> REG_RVALID_O)
    else $error("no valid");
  chk_valid_one: assert property (CE_I && !REG_RD_I |=> !REG_RVALID_O)
    else $error("long valid");
  chk_mask_wr: assert property (s_wr |=> OPER_MASK_O == $past(REG_WDATA_I, 2))
    else $error("mask lost");
  chk_mask_hold: assert property (
    CE_I && !(REG_WR_I && REG_ADDR_I == 2'h0) |=> ##1 $stable(OPER_MASK_O))
    else $error("mask moved");
  chk_oper_gate: assert property (
    CE_I |=> OPER_EVENT_O == ($past(OPER_COND_I) & OPER_MASK_O))
    else $error("oper gate");
  chk_rd_latch: assert property (
    CE_I && REG_RD_I && REG_ADDR_I == 2'h1 |=> REG_RDATA_O == QUES_EVENT_O)
    else $error("read value");
  // Without a read no latched bit may drop
  chk_latch_hold: assert property (
    CE_I && !(REG_RD_I && REG_ADDR_I == 2'h1) |=> ##1
    (~QUES_EVENT_O & $past(QUES_EVENT_O)) == 16'h0)
    else $error("bit dropped");
  chk_unused_zero: assert property (QUES_EVENT_O[15] == 1'h0 && QUES_EVENT_O[0] == 1'h0)
    else $error("unused bit");
  // A low enable must freeze every registered output
  chk_ce_freeze: assert property (
    !CE_I |=> $stable(OPER_MASK_O) && $stable(QUES_EVENT_O) && $stable(REG_RVALID_O)
    && $stable(REG_RDATA_O) && $stable(OPER_EVENT_O))
    else $error("moved while frozen");
endmodule
bind sreg_status_group sreg_asserts i_sreg_asserts (.CLK_I, .RESETN_I, .CE_I, .REG_ADDR_I,
  .REG_WR_I, .REG_RD_I, .REG_WDATA_I, .REG_RDATA_O, .REG_RVALID_O, .OPER_COND_I,
  .OPER_EVENT_O, .OPER_MASK_O, .QUES_EVENT_O);

// *** verification/sreg_status_group_tb.sv ***
// Bench for the status event register group
`timescale 1ns/1ps
module sreg_status_group_tb;
  reg c = 1'h0, n = 1'h0, w = 1'h0, r = 1'h0, e = 1'h1;
  reg [1:0] a = 2'h0;
  reg [15:0] d = 16'h0, oc = 16'h0, fl = 16'h0;
  wire [15:0] q, oe, om, qe;
  wire v;
  integer err_count = 0, checked = 0, i;
  sreg_status_group i_sreg_status_group (.CLK_I(c), .RESETN_I(n), .CE_I(e), .REG_ADDR_I(a),
    .REG_WR_I(w), .REG_RD_I(r), .REG_WDATA_I(d), .REG_RDATA_O(q), .REG_RVALID_O(v),
    .OPER_COND_I(oc), .OPER_EVENT_O(oe), .OPER_MASK_O(om), .QUES_EVENT_O(qe),
    .POWER_SWITCH_OFF_FLAG_I(fl[14]), .PARALLEL_WAIT_SLAVES_FLAG_I(fl[13]),
    .PARALLEL_ERROR_FLAG_I(fl[12]), .GENERAL_ERROR_FLAG_I(fl[11]), .PARALLEL_ACK_FLAG_I(fl[10]),
    .UNDER_VOLTAGE_FAULT_FLAG_I(fl[9]), .ENABLE_FAULT_FLAG_I(fl[8]), .INTERLOCK_FAULT_FLAG_I(fl[7]),
    .OUTPUT_OFF_FLAG_I(fl[6]), .SHUT_OFF_FLAG_I(fl[5]), .OVER_VOLTAGE_FAULT_FLAG_I(fl[4]),
    .FOLDBACK_FAULT_FLAG_I(fl[3]), .OVER_TEMP_FAULT_FLAG_I(fl[2]), .AC_FAULT_FLAG_I(fl[1]));
  initial
  begin
    forever #5 c = ~c;
  end
  task cmp(input [15:0] g, input [15:0] e);
    checked = checked + 1;
    if (g !== e)
    begin
      err_count = err_count + 1;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wrt(input [1:0] x, input [15:0] y);
    @(posedge c) #1 {w, a, d} = {1'h1, x, y};
    @(posedge c) #1 w = 1'h0;
  endtask
  task rdc(input [1:0] x, input [15:0] e);
    @(posedge c) #1 {r, a} = {1'h1, x};
    @(posedge c) #1 r = 1'h0;
    cmp(q, e);
    cmp({15'h0, v}, 16'h1);
  endtask
  task results;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ====
  // Tests
  initial
  begin
    #10000 err_count = err_count + 1;
    results;
  end
  initial
  begin
    repeat (3) @(posedge c);
    #1 n = 1'h1;
    rdc(2'h0, 16'h0);
    rdc(2'h3, 16'h0);
    wrt(2'h0, 16'hffff);
    wrt(2'h0, 16'ha5c3);
    oc = 16'h3c3c;
    wrt(2'h1, 16'hffff);
    wrt(2'h3, 16'h1234);
    rdc(2'h0, 16'ha5c3);
    cmp(oe, 16'h2400);
    cmp(om, 16'ha5c3);
    rdc(2'h1, 16'h0);
    rdc(2'h2, 16'h0);
    wrt(2'h2, 16'hffff);
    // One-cycle pulse per flag, so the bit must survive on its own until read
    for (i = 1; i < 15; i = i + 1)
    begin
      fl = 16'h1 << i;
      @(posedge c) #1 fl = 16'h0;
      rdc(2'h1, 16'h1 << i);
      cmp(qe, 16'h1 << i);
      rdc(2'h1, 16'h0);
    end
    // Enable low: a write and a flag pulse must both be ignored
    @(posedge c) #1 e = 1'h0;
    wrt(2'h0, 16'h0f0f);
    fl = 16'h0004;
    @(posedge c) #1 fl = 16'h0;
    e = 1'h1;
    cmp(om, 16'ha5c3);
    rdc(2'h0, 16'ha5c3);
    rdc(2'h1, 16'h0);
    fl = 16'hffff;
    rdc(2'h1, 16'h7ffe);
    wrt(2'h2, 16'h2000);
    rdc(2'h1, 16'h7ffe);
    rdc(2'h1, 16'h2000);
    fl = 16'h0;
    rdc(2'h1, 16'h2000);
    rdc(2'h1, 16'h0);
    // Reset in mid-run must bring both masks back to zero
    @(posedge c) #1 n = 1'h0;
    repeat (2) @(posedge c);
    #1 n = 1'h1;
    cmp(om, 16'h0);
    cmp(qe, 16'h0);
    rdc(2'h0, 16'h0);
    rdc(2'h2, 16'h0);
    results;
  end
endmodule
